// >>> verilog/pin_state_pkg.sv
// Constants and types shared by the pin-state power control design
package pin_state_pkg;

  // Prioritised power states, highest first
  typedef enum logic [2:0] {
    st_reset,
    st_refresh,
    st_sleep,
    st_idle,
    st_general_pd,
    st_normal
  } power_state_t;

  // Field positions inside the control bytes
  localparam int SYNC_CTRL_ENABLE_BIT = 2;
  localparam int PANEL_CTRL_SYNC_LOW_BIT = 3;
  localparam int PANEL_CTRL_STATIC_LOW_BIT = 4;
  localparam int PANEL_PIN_TRISTATE_BIT = 5;
  localparam int PANEL_POWER_ON_BIT = 2;
  localparam int HOST_RELEASE_BIT = 5;
  localparam int STRAP_BIT = 3;

  // Reset values of the software-written bits
  localparam logic PANEL_PIN_TRISTATE_RESET = 1'b1;
  localparam logic PANEL_POWER_ON_RESET = 1'b0;

  // Clock divide in the divided power states
  localparam int CLOCK_DIVIDE_RATIO = 8;
  localparam int DIVIDER_COUNT_WIDTH = 2;

  // Synchronised pin inputs, index into the pin vector
  localparam int PIN_RESET = 0;
  localparam int PIN_REFRESH_B = 1;
  localparam int PIN_STRAP = 2;
  localparam int PIN_COUNT = 3;

endpackage : pin_state_pkg

// >>> verilog/clock_divide_if.sv
// Interface between the pin-state controller and its clock divider
interface clock_divide_if;
  logic enable;
  logic src_clk;
  logic tick;

  modport master (
    output enable,
    output src_clk,
    input tick
  );

  modport divider (
    input enable,
    input src_clk,
    output tick
  );
endinterface : clock_divide_if

// >>> verilog/clock_divide_by8.sv
// Edge counter giving a toggle pulse every half period of the source clock divided by eight
module clock_divide_by8 #(
  parameter int RATIO = pin_state_pkg::CLOCK_DIVIDE_RATIO
) (
  input wire logic clk_sys,
  input wire logic rst_sync_b,
  clock_divide_if.divider div
);
  import pin_state_pkg::*;

  localparam logic [DIVIDER_COUNT_WIDTH-1:0] HALF_LAST = DIVIDER_COUNT_WIDTH'(RATIO / 2 - 1);

  logic src_prev;
  logic next_src_prev;
  logic [DIVIDER_COUNT_WIDTH-1:0] count;
  logic [DIVIDER_COUNT_WIDTH-1:0] next_count;
  logic rise;

  assign rise = div.src_clk & ~src_prev;

  always_comb begin
    next_src_prev = div.src_clk;
    next_count = count;
    div.tick = 1'b0;
    if (!div.enable) begin
      // Restart so the divided clock starts with a full half period
      next_count = '0;
    end else if (rise) begin
      if (count == HALF_LAST) begin
        next_count = '0;
        div.tick = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      src_prev <= 1'b0;
      count <= '0;
    end else begin
      src_prev <= next_src_prev;
      count <= next_count;
    end
  end
endmodule : clock_divide_by8

// >>> verilog/pin_state_power_control.sv
// Pin-state selection for memory, clock, sync, colour and panel pins across power states
module pin_state_power_control #(
  parameter int ADDR_WIDTH = 9,
  parameter int DATA_WIDTH = 16,
  parameter int COLOUR_WIDTH = 3,
  parameter int PANEL_WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic reset_pin,
  input wire logic refresh_pin_b,
  input wire logic memory_data_line3,
  input wire logic sleep_mode,
  input wire logic display_idle_mode,
  input wire logic general_pd_mode,
  input wire logic clock_divide_en,
  input wire logic internal_refresh,
  input wire logic self_refresh_en,
  input wire logic external_pclk_mode,
  input wire logic frame_select,
  input wire logic [7:0] sync_control_reg,
  input wire logic [7:0] panel_control_reg,
  input wire logic [7:0] host_release_reg,
  input wire logic panel_pin_control_wr,
  input wire logic [7:0] panel_pin_control_wdata,
  input wire logic panel_power_control_wr,
  input wire logic [7:0] panel_power_control_wdata,
  input wire logic host_access_req,
  input wire logic core_ras_b,
  input wire logic core_cas_b,
  input wire logic core_oe_b,
  input wire logic core_we_b,
  input wire logic [ADDR_WIDTH-1:0] core_addr,
  input wire logic core_data_oe,
  input wire logic core_pixel_clock,
  input wire logic core_memory_clock,
  input wire logic core_hsync,
  input wire logic core_vsync,
  input wire logic core_blank,
  input wire logic core_frame,
  input wire logic [COLOUR_WIDTH-1:0] core_colour,
  input wire logic [PANEL_WIDTH-1:0] core_panel_data,
  input wire logic core_shift_clock,
  input wire logic [1:0] core_panel_user,
  output pin_state_pkg::power_state_t power_state,
  output logic config_strap_bit3,
  output logic row_strobe_b,
  output logic column_strobe_b,
  output logic bank_a_output_enable,
  output logic bank_a_write_enable,
  output logic [ADDR_WIDTH-1:0] memory_addr,
  output logic memory_data_oe,
  output logic memory_clock_pin_out,
  output logic memory_clock_pin_oe,
  output logic secondary_video_clock_pin_out,
  output logic secondary_video_clock_pin_oe,
  output logic hsync_out,
  output logic vsync_out,
  output logic frame_output,
  output logic [COLOUR_WIDTH-1:0] colour_out,
  output logic [PANEL_WIDTH-1:0] panel_data_out,
  output logic panel_data_oe,
  output logic panel_shift_clock_out,
  output logic [1:0] panel_user_out,
  output logic panel_power_off_out,
  output logic panel_pin_tristate,
  output logic panel_power_on,
  output logic host_access_refused
);
  import pin_state_pkg::*;

  // Local reset release
  logic [1:0] rst_pipe;
  logic rst_sync_b;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_pipe[1];

  // Pin inputs: three stages, value changes only when stages two and three agree
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_s1;
  logic [PIN_COUNT-1:0] pin_s2;
  logic [PIN_COUNT-1:0] pin_s3;
  logic [PIN_COUNT-1:0] pin_val;
  logic [PIN_COUNT-1:0] next_pin_val;

  assign pin_raw = {memory_data_line3, refresh_pin_b, reset_pin};

  generate
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
      always_comb begin
        next_pin_val[i] = (pin_s2[i] == pin_s3[i]) ? pin_s3[i] : pin_val[i];
      end
      always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          pin_s1[i] <= (i == PIN_REFRESH_B);
          pin_s2[i] <= (i == PIN_REFRESH_B);
          pin_s3[i] <= (i == PIN_REFRESH_B);
          pin_val[i] <= (i == PIN_REFRESH_B) ? 1'b1 : 1'b0;
        end else begin
          pin_s1[i] <= pin_raw[i];
          pin_s2[i] <= pin_s1[i];
          pin_s3[i] <= pin_s2[i];
          pin_val[i] <= next_pin_val[i];
        end
      end
    end
  endgenerate

  // Divided clock for the divide states
  clock_divide_if div ();
  logic div_clock;
  logic next_div_clock;
  logic divide_active;

  assign div.src_clk = core_pixel_clock;
  assign div.enable = divide_active;

  clock_divide_by8 u_divider (
    .clk_sys(clk_sys),
    .rst_sync_b(rst_sync_b),
    .div(div)
  );

  // State selection and control bits
  power_state_t state;
  power_state_t next_state;
  logic next_strap;
  logic next_tristate;
  logic next_power_on;
  logic in_power_down;
  logic refresh_active;
  logic cas_low_seen;
  logic next_cas_low_seen;

  assign refresh_active = ~pin_val[PIN_REFRESH_B] | internal_refresh;
  assign in_power_down = (state == st_sleep) || (state == st_idle) || (state == st_general_pd);
  assign divide_active = clock_divide_en && ((state == st_idle) || (state == st_general_pd));

  always_comb begin
    // Device reset pin outranks every power request
    if (pin_val[PIN_RESET]) begin
      next_state = st_reset;
    end else if (refresh_active) begin
      next_state = st_refresh;
    end else if (sleep_mode) begin
      next_state = st_sleep;
    end else if (display_idle_mode) begin
      next_state = st_idle;
    end else if (general_pd_mode) begin
      next_state = st_general_pd;
    end else begin
      next_state = st_normal;
    end

    next_strap = config_strap_bit3;
    next_tristate = panel_pin_tristate;
    next_power_on = panel_power_on;
    if (pin_val[PIN_RESET]) begin
      next_strap = pin_val[PIN_STRAP];
      next_tristate = PANEL_PIN_TRISTATE_RESET;
      next_power_on = PANEL_POWER_ON_RESET;
    end else begin
      if (panel_pin_control_wr) begin
        next_tristate = panel_pin_control_wdata[PANEL_PIN_TRISTATE_BIT];
      end
      if (panel_power_control_wr) begin
        next_power_on = panel_power_control_wdata[PANEL_POWER_ON_BIT];
      end
    end

    // Self-refresh entry: column strobe falls one cycle before row strobe
    next_cas_low_seen = in_power_down && self_refresh_en && (state != st_refresh);

    next_div_clock = div_clock;
    if (!divide_active) begin
      next_div_clock = 1'b0;
    end else if (div.tick) begin
      next_div_clock = ~div_clock;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= st_reset;
      config_strap_bit3 <= 1'b0;
      panel_pin_tristate <= PANEL_PIN_TRISTATE_RESET;
      panel_power_on <= PANEL_POWER_ON_RESET;
      cas_low_seen <= 1'b0;
      div_clock <= 1'b0;
    end else begin
      state <= next_state;
      config_strap_bit3 <= next_strap;
      panel_pin_tristate <= next_tristate;
      panel_power_on <= next_power_on;
      cas_low_seen <= next_cas_low_seen;
      div_clock <= next_div_clock;
    end
  end

  assign power_state = state;

  // Pin values
  logic next_ras_b;
  logic next_cas_b;
  logic next_oe;
  logic next_we;
  logic [ADDR_WIDTH-1:0] next_addr;
  logic next_data_oe;
  logic next_mclk_out;
  logic next_mclk_oe;
  logic next_secondary_video_clock_pin_out;
  logic next_secondary_video_clock_pin_oe;
  logic next_hsync;
  logic next_vsync;
  logic next_frame;
  logic [COLOUR_WIDTH-1:0] next_colour;
  logic [PANEL_WIDTH-1:0] next_panel_data;
  logic next_panel_oe;
  logic next_shift_clock;
  logic [1:0] next_panel_user;
  logic next_power_off;
  logic sync_h;
  logic sync_v;
  logic clock_src;

  always_comb begin
    // Polarity already applied by the core; static overrides here
    sync_h = core_hsync;
    sync_v = core_vsync;
    if (panel_control_reg[PANEL_CTRL_SYNC_LOW_BIT]) begin
      sync_h = 1'b0;
      sync_v = 1'b0;
    end else if (!sync_control_reg[SYNC_CTRL_ENABLE_BIT]) begin
      sync_h = 1'b1;
      sync_v = 1'b1;
    end
    clock_src = divide_active ? div_clock : core_pixel_clock;

    next_ras_b = core_ras_b;
    next_cas_b = core_cas_b;
    next_oe = core_oe_b;
    next_we = core_we_b;
    next_addr = core_addr;
    next_data_oe = core_data_oe;
    next_hsync = sync_h;
    next_vsync = sync_v;
    next_frame = frame_select ? core_frame : core_blank;
    next_colour = core_colour;
    next_panel_data = core_panel_data;
    next_shift_clock = core_shift_clock;
    next_panel_user = core_panel_user;
    next_power_off = ~panel_power_on;

    case (state)
      st_reset: begin
        next_ras_b = 1'b1;
        next_cas_b = 1'b1;
        next_oe = 1'b1;
        next_we = 1'b1;
        next_addr = '0;
        next_data_oe = 1'b0;
        next_hsync = 1'b0;
        next_vsync = 1'b0;
        next_colour = '0;
        next_panel_data = '0;
        next_shift_clock = 1'b0;
        next_panel_user = 2'b00;
        next_power_off = 1'b1;
      end
      st_refresh: begin
        // Strobes run as normal for the whole refresh cycle
        next_oe = 1'b0;
        next_we = 1'b1;
        next_data_oe = 1'b0;
        next_ras_b = core_ras_b;
        next_cas_b = core_cas_b;
      end
      st_sleep, st_idle, st_general_pd: begin
        if (self_refresh_en) begin
          next_cas_b = 1'b0;
          next_ras_b = ~cas_low_seen;
        end else begin
          next_ras_b = 1'b1;
          next_cas_b = 1'b1;
        end
        next_oe = 1'b0;
        next_we = (state == st_general_pd) ? core_we_b : 1'b1;
        next_addr = (state == st_general_pd) ? core_addr : {ADDR_WIDTH{1'b1}};
        next_data_oe = 1'b0;
        next_hsync = 1'b0;
        next_vsync = 1'b0;
        next_colour = '0;
        next_panel_data = '0;
        next_shift_clock = 1'b0;
        next_power_off = 1'b1;
        if (frame_select) begin
          next_frame = 1'b0;
        end
        if (state == st_sleep) begin
          next_panel_user = panel_user_out;
        end
      end
      st_normal: begin
        next_ras_b = core_ras_b;
      end
      default: begin
        next_ras_b = 1'b1;
        next_cas_b = 1'b1;
      end
    endcase

    if (panel_control_reg[PANEL_CTRL_STATIC_LOW_BIT]) begin
      next_shift_clock = 1'b0;
    end
    next_panel_oe = ~panel_pin_tristate;

    // Memory clock is never driven internally; the secondary clock pin is driven only while config_strap_bit3 is set
    next_mclk_oe = 1'b0;
    next_mclk_out = core_memory_clock;
    next_secondary_video_clock_pin_oe = config_strap_bit3;
    next_secondary_video_clock_pin_out = clock_src;
    if (external_pclk_mode && !config_strap_bit3) begin
      next_secondary_video_clock_pin_oe = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      row_strobe_b <= 1'b1;
      column_strobe_b <= 1'b1;
      bank_a_output_enable <= 1'b1;
      bank_a_write_enable <= 1'b1;
      memory_addr <= '0;
      memory_data_oe <= 1'b0;
      memory_clock_pin_out <= 1'b0;
      memory_clock_pin_oe <= 1'b0;
      secondary_video_clock_pin_out <= 1'b0;
      secondary_video_clock_pin_oe <= 1'b0;
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
      frame_output <= 1'b0;
      colour_out <= '0;
      panel_data_out <= '0;
      panel_data_oe <= 1'b0;
      panel_shift_clock_out <= 1'b0;
      panel_user_out <= 2'b00;
      panel_power_off_out <= 1'b1;
    end else begin
      row_strobe_b <= next_ras_b;
      column_strobe_b <= next_cas_b;
      bank_a_output_enable <= next_oe;
      bank_a_write_enable <= next_we;
      memory_addr <= next_addr;
      memory_data_oe <= next_data_oe;
      memory_clock_pin_out <= next_mclk_out;
      memory_clock_pin_oe <= next_mclk_oe;
      secondary_video_clock_pin_out <= next_secondary_video_clock_pin_out;
      secondary_video_clock_pin_oe <= next_secondary_video_clock_pin_oe;
      hsync_out <= next_hsync;
      vsync_out <= next_vsync;
      frame_output <= next_frame;
      colour_out <= next_colour;
      panel_data_out <= next_panel_data;
      panel_data_oe <= next_panel_oe;
      panel_shift_clock_out <= next_shift_clock;
      panel_user_out <= next_panel_user;
      panel_power_off_out <= next_power_off;
    end
  end

  // Host refusal follows the request combinationally
  assign host_access_refused = host_access_req && (state == st_sleep) && host_release_reg[HOST_RELEASE_BIT];
endmodule : pin_state_power_control

// >>> tb/mem_panel_model.sv
// Behavioural display memory partner: strap source on the data line and refresh watcher
module mem_panel_model (
  input wire logic clk_sys,
  input wire logic strap_level,
  input wire logic memory_data_oe,
  input wire logic row_strobe_b,
  input wire logic column_strobe_b,
  output logic memory_data_line3,
  output logic cbr_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic churn = 1'b0;
  logic column_last = 1'b1;
  initial cbr_seen = 1'b0;
  always @(posedge clk_sys) begin
    churn <= ~churn;
    column_last <= column_strobe_b;
    // Column falling while row stays high enters self-refresh
    if (column_last && !column_strobe_b && row_strobe_b) begin
      cbr_seen <= 1'b1;
    end
  end
  // Strap pull level only while the bus is an input, else a churning value
  assign memory_data_line3 = memory_data_oe ? churn : strap_level;
endmodule : mem_panel_model

// >>> tb/pin_state_power_control_chk.sv
// Port assertions for the pin-state power controller
module pin_state_power_control_chk
  import pin_state_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sleep_mode,
  input wire logic self_refresh_en,
  input wire logic [7:0] panel_control_reg,
  input wire logic [7:0] host_release_reg,
  input wire logic host_access_req,
  input wire pin_state_pkg::power_state_t power_state,
  input wire logic row_strobe_b,
  input wire logic column_strobe_b,
  input wire logic bank_a_output_enable,
  input wire logic bank_a_write_enable,
  input wire logic [8:0] memory_addr,
  input wire logic memory_data_oe,
  input wire logic memory_clock_pin_oe,
  input wire logic hsync_out,
  input wire logic vsync_out,
  input wire logic [1:0] panel_user_out,
  input wire logic panel_power_on,
  input wire logic panel_power_off_out,
  input wire logic host_access_refused
);
  logic [2:0] up_cnt;
  logic [2:0] next_up_cnt;
  logic ready;
  // Design reset lags rst_b
  always_comb begin
    next_up_cnt = (up_cnt == 3'h7) ? up_cnt : up_cnt + 3'h1;
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      up_cnt <= 3'h0;
    end else begin
      up_cnt <= next_up_cnt;
    end
  end
  assign ready = (up_cnt == 3'h7);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_refuse;
    host_access_refused == (host_access_req && power_state == st_sleep && host_release_reg[HOST_RELEASE_BIT]);
  endproperty
  a_refuse: assert property (p_refuse) else $error("host refusal wrong");
  property p_clk_pin;
    !memory_clock_pin_oe;
  endproperty
  a_clk_pin: assert property (p_clk_pin) else $error("memory clock pin driven");
  property p_prio;
    ready && $past(sleep_mode) |-> power_state inside {st_reset, st_refresh, st_sleep};
  endproperty
  a_prio: assert property (p_prio) else $error("sleep lost priority");
  property p_pd_strobes;
    ready && $past(power_state) inside {st_sleep, st_idle, st_general_pd} && !$past(self_refresh_en)
      |-> row_strobe_b && column_strobe_b;
  endproperty
  a_pd_strobes: assert property (p_pd_strobes) else $error("strobes low in power-down");
  property p_self_refresh;
    ready && $past(power_state) inside {st_sleep, st_idle, st_general_pd} && $past(self_refresh_en)
      && $past(power_state, 2) inside {st_sleep, st_idle, st_general_pd} && $past(self_refresh_en, 2)
      |-> !row_strobe_b && !column_strobe_b;
  endproperty
  a_self_refresh: assert property (p_self_refresh) else $error("strobes not low in self-refresh");
  property p_reset_pins;
    ready && $past(power_state) == st_reset |-> row_strobe_b && column_strobe_b && bank_a_output_enable
      && bank_a_write_enable && memory_addr == 9'h000 && !memory_data_oe;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("reset pin levels wrong");
  property p_updating;
    $past(power_state) inside {st_sleep, st_idle} |-> !bank_a_output_enable && bank_a_write_enable;
  endproperty
  a_updating: assert property (p_updating) else $error("memory enables wrong");
  property p_sync_low;
    ready && $past(panel_control_reg[PANEL_CTRL_SYNC_LOW_BIT]) && $past(power_state) == st_normal
      |-> !hsync_out && !vsync_out;
  endproperty
  a_sync_low: assert property (p_sync_low) else $error("syncs not static low");
  property p_sleep_hold;
    $past(power_state) == st_sleep && $past(power_state, 2) == st_sleep |-> $stable(panel_user_out);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("held pins moved");
  property p_power_off;
    ready && $past(power_state) == st_normal |-> panel_power_off_out == !$past(panel_power_on);
  endproperty
  a_power_off: assert property (p_power_off) else $error("panel power output wrong");
  c_refused: cover property (host_access_refused);
  c_self_refresh: cover property (power_state == st_general_pd && !row_strobe_b);
  c_sync_low: cover property (power_state == st_normal && !hsync_out && panel_control_reg[3]);
endmodule : pin_state_power_control_chk

bind pin_state_power_control pin_state_power_control_chk u_pin_state_power_control_chk (.*);

// >>> tb/pin_state_power_control_tb.sv
// Self-checking bench for the pin-state power controller
module pin_state_power_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pin_state_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b, reset_pin, refresh_pin_b, sleep_mode, display_idle_mode, general_pd_mode, clock_divide_en;
  logic internal_refresh, self_refresh_en, external_pclk_mode, frame_select, host_access_req, strap_level;
  logic panel_pin_control_wr, panel_power_control_wr, core_ras_b, core_cas_b, core_oe_b, core_we_b, core_data_oe;
  logic core_pixel_clock, core_memory_clock, core_hsync, core_vsync, core_blank, core_frame, core_shift_clock;
  logic [7:0] sync_control_reg, panel_control_reg, host_release_reg, panel_pin_control_wdata;
  logic [7:0] panel_power_control_wdata, core_panel_data, panel_data_out;
  logic [8:0] core_addr, memory_addr;
  logic [2:0] core_colour, colour_out;
  logic [1:0] core_panel_user, panel_user_out;
  power_state_t power_state;
  logic memory_data_line3, config_strap_bit3, row_strobe_b, column_strobe_b, bank_a_output_enable;
  logic bank_a_write_enable, memory_data_oe, memory_clock_pin_out, memory_clock_pin_oe, secondary_video_clock_pin_out;
  logic secondary_video_clock_pin_oe, hsync_out, vsync_out, frame_output, panel_data_oe, panel_shift_clock_out;
  logic panel_power_off_out, panel_pin_tristate, panel_power_on, host_access_refused, cbr_seen, last_level;
  int error_cnt = 0;
  int n_checks = 0;
  int toggles;
  logic [7:0] wr_val [4] = '{8'h20, 8'hFB, 8'h04, 8'hDF};
  logic wr_sel [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [4:0] mode_tab [6] = '{5'b00111, 5'b00011, 5'b00001, 5'b01111, 5'b10100, 5'b00000};
  power_state_t state_tab [6] = '{st_sleep, st_idle, st_general_pd, st_refresh, st_refresh, st_normal};
  logic [15:0] sync_tab [3] = '{16'h0000, 16'h0408, 16'h0008};
  logic sync_exp [3] = '{1'b1, 1'b0, 1'b0};

  pin_state_power_control u_pin_state_power_control (.*);
  mem_panel_model u_mem_panel_model (.*);

  always #2.5 clk_sys = ~clk_sys;
  // Busy core traffic, so forced levels are seen against moving sources
  always @(posedge clk_sys) begin
    {core_oe_b, core_we_b, core_data_oe} <= ~{core_oe_b, core_we_b, core_data_oe};
    {core_memory_clock, core_blank, core_frame} <= ~{core_memory_clock, core_blank, core_frame};
  end

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit
  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic write_reg(input logic power_sel, input logic [7:0] d);
    @(posedge clk_sys);
    panel_pin_control_wr <= !power_sel;
    panel_power_control_wr <= power_sel;
    panel_pin_control_wdata <= d;
    panel_power_control_wdata <= d;
    @(posedge clk_sys);
    panel_pin_control_wr <= 1'b0;
    panel_power_control_wr <= 1'b0;
    #1;
  endtask : write_reg
  // Mode word: refresh request pin, internal refresh, sleep, idle, general power-down
  task automatic set_modes(input logic [4:0] m, input int n);
    @(posedge clk_sys);
    refresh_pin_b <= !m[4];
    {internal_refresh, sleep_mode, display_idle_mode, general_pd_mode} <= m[3:0];
    settle(n);
  endtask : set_modes
  task automatic conclude();
    $display("Checks made %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end

  initial begin
    {rst_b, sleep_mode, display_idle_mode, general_pd_mode, clock_divide_en, internal_refresh} = 6'h00;
    {self_refresh_en, external_pclk_mode, frame_select, host_access_req, core_pixel_clock} = 5'h00;
    {panel_pin_control_wr, panel_power_control_wr, core_shift_clock, core_vsync} = 4'h0;
    {reset_pin, strap_level, refresh_pin_b, core_ras_b, core_cas_b, core_hsync} = 6'h3F;
    {core_oe_b, core_we_b, core_data_oe, core_memory_clock, core_blank, core_frame} = 6'h2A;
    {sync_control_reg, panel_control_reg, host_release_reg} = {8'h04, 8'h00, 8'h00};
    {panel_pin_control_wdata, panel_power_control_wdata, core_panel_data} = {8'h00, 8'h00, 8'hC3};
    {core_addr, core_colour, core_panel_user} = {9'h0A5, 3'h5, 2'h2};
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    settle(12);
    check_word("power_state", 16'(st_reset), 16'(power_state));
    check_word("reset_levels", 16'h3C00, 16'({row_strobe_b, column_strobe_b, bank_a_output_enable,
      bank_a_write_enable, memory_addr, memory_data_oe}));
    check_word("panel_defaults", 16'h0005, 16'({panel_pin_tristate, panel_power_on, panel_power_off_out}));
    check_bit("config_strap_bit3", 1'b1, config_strap_bit3);
    check_bit("secondary_clock_oe", 1'b1, secondary_video_clock_pin_oe);
    @(posedge clk_sys);
    reset_pin <= 1'b0;
    settle(10);
    check_word("power_state", 16'(st_normal), 16'(power_state));
    check_word("memory_addr", 16'h00A5, 16'(memory_addr));
    check_word("colour_out", 16'h0005, 16'(colour_out));
    for (int i = 0; i < 4; i++) begin
      write_reg(wr_sel[i], wr_val[i]);
      check_bit("written_bit", wr_val[i][wr_sel[i] ? PANEL_POWER_ON_BIT : PANEL_PIN_TRISTATE_BIT],
        wr_sel[i] ? panel_power_on : panel_pin_tristate);
      settle(1);
      check_bit("panel_side_pin", !wr_val[i][wr_sel[i] ? PANEL_POWER_ON_BIT : PANEL_PIN_TRISTATE_BIT],
        wr_sel[i] ? panel_power_off_out : panel_data_oe);
    end
    check_word("panel_data_out", 16'h00C3, 16'(panel_data_out));
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      {sync_control_reg, panel_control_reg} <= sync_tab[i];
      settle(3);
      check_word("syncs", {14'h0, sync_exp[i], sync_exp[i]}, 16'({hsync_out, vsync_out}));
    end
    @(posedge clk_sys);
    {sync_control_reg, panel_control_reg, core_shift_clock} <= {8'h04, 8'h10, 1'b1};
    settle(3);
    check_bit("panel_shift_clock_out", 1'b0, panel_shift_clock_out);
    for (int i = 0; i < 6; i++) begin
      set_modes(mode_tab[i], 6);
      check_word("power_state", 16'(state_tab[i]), 16'(power_state));
    end
    @(posedge clk_sys);
    {frame_select, host_release_reg, host_access_req} <= {1'b1, 8'h20, 1'b1};
    set_modes(5'b00100, 4);
    check_word("sleep_strobes", 16'h0003, 16'({row_strobe_b, column_strobe_b}));
    check_word("memory_addr", 16'h01FF, 16'(memory_addr));
    check_word("enables", 16'h0001, 16'({bank_a_output_enable, bank_a_write_enable}));
    check_bit("frame_output", 1'b0, frame_output);
    check_bit("host_access_refused", 1'b1, host_access_refused);
    @(posedge clk_sys);
    {core_panel_user, host_release_reg} <= {2'h1, 8'hDF};
    settle(3);
    check_word("panel_user_out", 16'h0002, 16'(panel_user_out));
    check_bit("host_access_refused", 1'b0, host_access_refused);
    @(posedge clk_sys);
    {frame_select, host_access_req} <= 2'b00;
    set_modes(5'b00000, 3);
    check_bit("cbr_seen", 1'b0, cbr_seen);
    @(posedge clk_sys);
    self_refresh_en <= 1'b1;
    set_modes(5'b00001, 4);
    check_word("self_refresh_strobes", 16'h0000, 16'({row_strobe_b, column_strobe_b}));
    check_bit("cbr_seen", 1'b1, cbr_seen);
    @(posedge clk_sys);
    {self_refresh_en, core_ras_b} <= 2'b00;
    set_modes(5'b01000, 4);
    check_word("refresh_strobes", 16'h0001, 16'({row_strobe_b, column_strobe_b}));
    @(posedge clk_sys);
    {core_ras_b, clock_divide_en, external_pclk_mode} <= 3'b111;
    set_modes(5'b00010, 4);
    toggles = 0;
    last_level = secondary_video_clock_pin_out;
    repeat (64) begin
      @(posedge clk_sys);
      core_pixel_clock <= ~core_pixel_clock;
      #1;
      toggles += (secondary_video_clock_pin_out !== last_level) ? 1 : 0;
      last_level = secondary_video_clock_pin_out;
    end
    check_bit("divided_clock_rate", 1'b1, toggles >= 7 && toggles <= 9);
    check_bit("memory_clock_pin_oe", 1'b0, memory_clock_pin_oe);
    @(posedge clk_sys);
    {strap_level, reset_pin} <= 2'b01;
    set_modes(5'b11111, 10);
    check_word("power_state", 16'(st_reset), 16'(power_state));
    check_word("panel_defaults", 16'h0002, 16'({panel_pin_tristate, panel_power_on}));
    check_bit("config_strap_bit3", 1'b0, config_strap_bit3);
    check_bit("secondary_clock_oe", 1'b0, secondary_video_clock_pin_oe);
    conclude();
  end
endmodule : pin_state_power_control_tb
